// >>> common/evi_pkg.sv
// Overview of operation
// - eighteen vectored sources grouped into eight levels
// - level priority register, then lowest vector wins
// - grant disables interrupts; core fetches 16-bit vector
// - timer-1 overflow, watchdog cleared by acknowledge
// - level one: F6H and F4H, software cleared
// - ECH shares level three, software cleared
// - E0H serial bus; pins at FEH-F8H and DEH-D8H
// - external pins request on falling edge
// - vectors below 256; reset start 0100H
// - enable/disable instructions drive mode bit 0
// - service needs global, level and source enable
// - request register read-only, one flag per level
// - mask bit 1 enables its level
// - mask register at DDH, read and write
// - reset clears mode bits 1 and 0
// - groups A 0-1, B 2-4, C 5-7
// - priority bits 7,4,1 order the groups
// - hidden pending cleared after core acknowledge
package evi_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NSRC = 18; // sources in the vector table
    localparam int NLVL = 8; // request levels
    localparam int ADDR_W = 12; // apb byte address width

    // ----------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_REQ = 10'h0dc; // level request, read only
    localparam logic [9:0] IDX_MASK = 10'h0dd; // level_mask_reg
    localparam logic [9:0] IDX_MODE = 10'h0de; // system_mode_reg
    localparam logic [9:0] IDX_PRIO = 10'h0ff; // level_priority_reg
    localparam logic [9:0] IDX_SRC_EN = 10'h100; // per-source enables
    localparam logic [9:0] IDX_PEND = 10'h101; // per-source pending flags

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int MODE_GIE = 0; // global enable bit
    localparam int MODE_B1 = 1; // plain mode bit, cleared by reset
    localparam int MODE_FAST_LO = 2; // fast level field low bit
    localparam int MODE_FAST_HI = 4; // fast level field high bit
    localparam int PRIO_GA = 1; // group order bit (low)
    localparam int PRIO_GB = 4; // group order bit (middle)
    localparam int PRIO_GC = 7; // group order bit (high)
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [2:0] FAST_RST = 3'h0;
    localparam logic [NSRC-1:0] EN_RST = 18'h00000;
    localparam logic [15:0] RESET_PC = 16'h0100; // program start address

    // ----------------------------------------------------------------
    // group orders selected by priority bits {7,4,1}
    // ----------------------------------------------------------------
    localparam logic [2:0] GO_BCA = 3'h1;
    localparam logic [2:0] GO_ABC = 3'h2;
    localparam logic [2:0] GO_BAC = 3'h3;
    localparam logic [2:0] GO_CAB = 3'h4;
    localparam logic [2:0] GO_CBA = 3'h5;
    localparam logic [2:0] GO_ACB = 3'h6;

    // ----------------------------------------------------------------
    // source table, index order is descending vector address
    // ----------------------------------------------------------------
    localparam logic [NSRC-1:0][7:0] VEC = {
        8'hd8, 8'hda, 8'hdc, 8'hde, 8'he0, 8'he2, 8'he4, 8'he6, 8'hea,
        8'hec, 8'hf0, 8'hf2, 8'hf4, 8'hf6, 8'hf8, 8'hfa, 8'hfc, 8'hfe};
    localparam logic [NSRC-1:0][2:0] LVL = {
        3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h5, 3'h5, 3'h4, 3'h3,
        3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
    // timer-1 overflow (index 9) and watchdog (index 10)
    localparam logic [NSRC-1:0] HW_CLR = 18'h00600;
    // external pins 0..3 feed sources 0..3, pins 4..7 feed 14..17
    localparam int PIN_HI_OFS = 10;

endpackage : evi_pkg

// >>> hw/evi_level_arb.sv
// level arbiter: group and subgroup order from the priority byte
module evi_level_arb #(
    parameter int NLVL = 8
) (
    input wire logic [7:0] req,
    input wire logic [7:0] prio,
    output logic win_vld,
    output logic [2:0] win_lvl
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    // the group split is hard wired for exactly eight levels
    if (NLVL != 8) begin : g_bad
        $error("evi_level_arb serves eight levels only");
    end

    logic [1:0][2:0] ord_a; // group A order, first is strongest
    logic [1:0][2:0] sub_b; // levels 3/4 inside group B
    logic [2:0][2:0] ord_b; // group B order
    logic [1:0][2:0] sub_c; // levels 6/7 inside group C
    logic [2:0][2:0] ord_c; // group C order
    logic [7:0][2:0] ord; // full order, element 7 is strongest

    // ----------------------------------------------------------------
    // build order, then take the strongest requesting level
    // ----------------------------------------------------------------
    always_comb begin
        ord_a = prio[0] ? {3'h1, 3'h0} : {3'h0, 3'h1};
        sub_b = prio[3] ? {3'h4, 3'h3} : {3'h3, 3'h4};
        ord_b = prio[2] ? {sub_b, 3'h2} : {3'h2, sub_b};
        sub_c = prio[6] ? {3'h7, 3'h6} : {3'h6, 3'h7};
        ord_c = prio[5] ? {sub_c, 3'h5} : {3'h5, sub_c};
        // codes 000 and 111 are unused; they fall back to A>B>C
        unique case ({prio[7], prio[4], prio[1]})
            evi_pkg::GO_BCA: ord = {ord_b, ord_c, ord_a};
            evi_pkg::GO_BAC: ord = {ord_b, ord_a, ord_c};
            evi_pkg::GO_CAB: ord = {ord_c, ord_a, ord_b};
            evi_pkg::GO_CBA: ord = {ord_c, ord_b, ord_a};
            evi_pkg::GO_ACB: ord = {ord_a, ord_c, ord_b};
            default: ord = {ord_a, ord_b, ord_c};
        endcase
        win_vld = |req;
        win_lvl = 3'h0;
        // weakest first so the strongest hit is assigned last
        for (int i = 0; i < 8; i++) begin
            if (req[ord[i]]) begin
                win_lvl = ord[i];
            end
        end
    end

endmodule : evi_level_arb

// >>> hw/evi_ctrl.sv
// vectored interrupt unit: apb registers, pending flags, arbitration
//
// Register access over APB is this design's own decision.
module evi_ctrl (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [evi_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [evi_pkg::NSRC-1:0] src_evt,
    input wire logic [7:0] ext_pin,
    input wire logic global_enable_instr,
    input wire logic global_disable_instr,
    input wire logic request_acknowledge,
    output logic int_req,
    output logic [7:0] int_vector,
    output logic [15:0] reset_pc
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic gie; // global enable, mode bit 0
        logic mode_b1; // mode bit 1
        logic [2:0] fast; // fast level field, stored only
        logic [7:0] mask; // level mask
        logic [7:0] prio; // level priority
        logic [evi_pkg::NSRC-1:0] en; // source enables
        logic [evi_pkg::NSRC-1:0] pend; // source pending flags
        logic [7:0] pin_d; // last sampled pin levels
        logic irq; // request to the core
        logic [7:0] vec; // vector location of the winner
        logic [4:0] sidx; // winning source index
        logic [31:0] rdata; // read data for the access phase
    } evi_state_t;

    evi_state_t st_r; // registered state
    evi_state_t st_nxt; // next state

    // ----------------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------------
    logic [9:0] idx; // register index from the byte address
    logic wr_acc; // write access phase
    logic hit; // address maps to a register
    logic [evi_pkg::NSRC-1:0] evt; // set events this cycle
    logic [evi_pkg::NSRC-1:0] act; // pending and enabled
    logic [evi_pkg::NSRC-1:0] clr; // clear requests this cycle
    logic [7:0] fall; // falling edges on pins
    logic [7:0] lreq; // per-level request flags
    logic [7:0] lgo; // levels allowed to compete
    logic win_vld; // some level may be served
    logic [2:0] win_lvl; // served level
    logic [4:0] sel; // served source

    assign idx = paddr[evi_pkg::ADDR_W-1:2];
    assign wr_acc = psel && penable && pwrite;
    assign hit = (idx == evi_pkg::IDX_REQ) || (idx == evi_pkg::IDX_MASK) ||
        (idx == evi_pkg::IDX_MODE) || (idx == evi_pkg::IDX_PRIO) ||
        (idx == evi_pkg::IDX_SRC_EN) || (idx == evi_pkg::IDX_PEND);

    // ----------------------------------------------------------------
    // level arbiter
    // ----------------------------------------------------------------
    // only unmasked levels compete, and none while globally disabled
    assign lgo = lreq & st_r.mask & {8{st_r.gie}};

    evi_level_arb #(
        .NLVL(evi_pkg::NLVL)
    ) u_arb (
        .req(lgo),
        .prio(st_r.prio),
        .win_vld(win_vld),
        .win_lvl(win_lvl)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // pins are synchronous; falling edge is high then low
        fall = st_r.pin_d & ~ext_pin;
        st_nxt.pin_d = ext_pin;
        // peripheral events, pin slots are overridden by the pins
        evt = src_evt;
        for (int k = 0; k < 8; k++) begin
            if (k < 4) begin
                evt[k] = fall[k];
            end else begin
                evt[k + evi_pkg::PIN_HI_OFS] = fall[k];
            end
        end
        // per-level flags gather all enabled pending sources
        act = st_r.pend & st_r.en;
        lreq = 8'h00;
        for (int i = 0; i < evi_pkg::NSRC; i++) begin
            if (act[i]) begin
                lreq[evi_pkg::LVL[i]] = 1'b1;
            end
        end
        // in-level winner: higher index means lower vector address
        sel = 5'h00;
        for (int i = 0; i < evi_pkg::NSRC; i++) begin
            if (act[i] && (evi_pkg::LVL[i] == win_lvl)) begin
                sel = 5'(i);
            end
        end
        // request and vector recomputed every cycle
        st_nxt.irq = win_vld;
        st_nxt.vec = evi_pkg::VEC[sel];
        st_nxt.sidx = sel;
        // software clears by writing 0; hidden flags cannot be hit
        clr = '0;
        if (wr_acc && (idx == evi_pkg::IDX_PEND)) begin
            clr = ~pwdata[evi_pkg::NSRC-1:0] & ~evi_pkg::HW_CLR;
        end
        // acknowledge clears only a hardware-cleared winner
        if (request_acknowledge && st_r.irq && evi_pkg::HW_CLR[st_r.sidx]) begin
            clr[st_r.sidx] = 1'b1;
        end
        // a new event in the same cycle beats its clear
        st_nxt.pend = (st_r.pend & ~clr) | evt;
        // register writes; the request register ignores writes
        if (wr_acc) begin
            unique case (idx)
                evi_pkg::IDX_MASK: begin
                    st_nxt.mask = pwdata[7:0];
                end
                evi_pkg::IDX_MODE: begin
                    st_nxt.gie = pwdata[evi_pkg::MODE_GIE];
                    st_nxt.mode_b1 = pwdata[evi_pkg::MODE_B1];
                    st_nxt.fast = pwdata[evi_pkg::MODE_FAST_HI:evi_pkg::MODE_FAST_LO];
                end
                evi_pkg::IDX_PRIO: begin
                    st_nxt.prio = pwdata[7:0];
                end
                evi_pkg::IDX_SRC_EN: begin
                    st_nxt.en = pwdata[evi_pkg::NSRC-1:0];
                end
                default: begin
                    // read-only or unmapped: nothing stored
                end
            endcase
        end
        // instructions override a direct write in the same cycle
        if (global_enable_instr) begin
            st_nxt.gie = 1'b1;
        end
        if (global_disable_instr) begin
            st_nxt.gie = 1'b0;
        end
        // a grant shuts further requests out until re-enabled
        if (request_acknowledge && st_r.irq) begin
            st_nxt.gie = 1'b0;
        end
        // read data prepared during setup, shown in access phase
        st_nxt.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (idx)
                evi_pkg::IDX_REQ: st_nxt.rdata[7:0] = lreq;
                evi_pkg::IDX_MASK: st_nxt.rdata[7:0] = st_r.mask;
                evi_pkg::IDX_MODE: st_nxt.rdata[4:0] = {st_r.fast, st_r.mode_b1, st_r.gie};
                evi_pkg::IDX_PRIO: st_nxt.rdata[7:0] = st_r.prio;
                evi_pkg::IDX_SRC_EN: st_nxt.rdata[evi_pkg::NSRC-1:0] = st_r.en;
                // hidden hardware-cleared flags read as zero
                evi_pkg::IDX_PEND: begin
                    st_nxt.rdata[evi_pkg::NSRC-1:0] = st_r.pend & ~evi_pkg::HW_CLR;
                end
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // mask and priority are undefined by nature; zero is chosen so
    // nothing is served before software initialises them
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r.gie <= 1'b0;
            st_r.mode_b1 <= 1'b0;
            st_r.fast <= evi_pkg::FAST_RST;
            st_r.mask <= evi_pkg::MASK_RST;
            st_r.prio <= evi_pkg::PRIO_RST;
            st_r.en <= evi_pkg::EN_RST;
            st_r.pend <= '0;
            st_r.pin_d <= 8'hff;
            st_r.irq <= 1'b0;
            st_r.vec <= 8'h00;
            st_r.sidx <= 5'h00;
            st_r.rdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero wait states: every access completes in its first cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata = st_r.rdata;
    assign int_req = st_r.irq;
    assign int_vector = st_r.vec;
    assign reset_pc = evi_pkg::RESET_PC;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    logic mode_wr; // direct write to the mode register
    logic pend_wr; // direct write to the pending register
    assign mode_wr = wr_acc && (idx == evi_pkg::IDX_MODE);
    assign pend_wr = wr_acc && (idx == evi_pkg::IDX_PEND);

    // grant, then enable drops, then the request goes away
    sequence s_grant;
        st_r.irq && request_acknowledge && !global_enable_instr && !mode_wr;
    endsequence
    sequence s_quiet;
        !global_enable_instr && !mode_wr;
    endsequence

    a_grant_disables: assert property (
        s_grant ##1 s_quiet |-> !st_r.gie ##1 !st_r.irq)
        else $error("grant did not disable further requests");

    a_enable_instr: assert property (
        global_enable_instr && !global_disable_instr && !request_acknowledge
        |=> st_r.gie)
        else $error("enable instruction did not set global enable");

    a_global_gate: assert property (
        !st_r.gie |=> !st_r.irq)
        else $error("request raised while globally disabled");

    a_mask_gate: assert property (
        st_r.mask == 8'h00 |=> !st_r.irq)
        else $error("request raised with every level masked");

    a_hw_clear: assert property (
        st_r.irq && request_acknowledge && st_r.vec == 8'hea && !src_evt[9]
        |=> !st_r.pend[9])
        else $error("timer-1 overflow flag survived acknowledge");

    a_sw_hold: assert property (
        st_r.pend[4] && request_acknowledge && !pend_wr |=> st_r.pend[4])
        else $error("software flag cleared without a write");

    a_pin_edge: assert property (
        st_r.pin_d[0] && !ext_pin[0] |=> st_r.pend[0])
        else $error("falling pin edge did not set pending");

    a_group_order: assert property (
        st_r.gie && st_r.prio[7] && !st_r.prio[4] && st_r.prio[1] &&
        (st_r.mask[7] && act[17] || st_r.mask[5] && act[11])
        |=> st_r.irq && st_r.vec <= 8'he4)
        else $error("group C did not win with order C>B>A");

    a_vec_range: assert property (
        st_r.irq |-> !st_r.vec[0] && st_r.vec >= 8'hd8)
        else $error("vector outside the table");

endmodule : evi_ctrl

// >>> testbench/evi_core_model.sv
// cpu core stand-in: acknowledges at instruction end and fetches vectors
module evi_core_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic int_req,
    input wire logic [7:0] int_vector,
    input wire logic ack_on,
    input wire logic [3:0] instr_len,
    output logic request_acknowledge,
    output logic [7:0] taken_vec,
    output logic [15:0] svc_addr,
    output logic [7:0] taken_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // vector rom and acknowledge timing
    // ----
    logic [7:0] rom [0:255]; // 256-byte vector area
    logic [3:0] cyc_r; // cycles spent in the current instruction
    logic [1:0] hold_r; // request needs two edges to fall after ack
    // rom pattern keeps the two vector bytes distinct
    initial begin
        for (int i = 0; i < 256; i++) begin
            rom[i] = 8'(i) ^ 8'h5a;
        end
    end
    // one ack pulse per grant, never while the old request is falling
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            request_acknowledge <= 1'b0;
            taken_vec <= 8'h00;
            svc_addr <= 16'h0000;
            taken_cnt <= 8'h00;
            cyc_r <= 4'h0;
            hold_r <= 2'h0;
        end else begin
            request_acknowledge <= 1'b0;
            if (hold_r != 2'h0) begin
                hold_r <= hold_r - 2'h1;
            end else if (int_req && ack_on) begin
                if (cyc_r >= instr_len) begin // end of instruction
                    request_acknowledge <= 1'b1;
                    taken_vec <= int_vector;
                    svc_addr <= {rom[int_vector], rom[int_vector + 8'h01]};
                    taken_cnt <= taken_cnt + 8'h01;
                    cyc_r <= 4'h0;
                    hold_r <= 2'h3;
                end else begin
                    cyc_r <= cyc_r + 4'h1;
                end
            end else begin
                cyc_r <= 4'h0;
            end
        end
    end
endmodule : evi_core_model

// >>> testbench/eight_level_vectored_interrupt_unit_bench.sv
// top of the bench: apb master, event driver, core model, checks
module eight_level_vectored_interrupt_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // signals
    // ----
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [evi_pkg::ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [evi_pkg::NSRC-1:0] src_evt = '0;
    logic [7:0] ext_pin = 8'hff; // pins idle high
    logic global_enable_instr = 1'b0;
    logic global_disable_instr = 1'b0;
    logic request_acknowledge;
    logic int_req;
    logic [7:0] int_vector;
    logic [15:0] reset_pc;
    logic ack_on = 1'b0; // core takes requests only when asked
    logic [3:0] instr_len = 4'h0; // 0 prompt core, larger is slow
    logic [7:0] taken_vec;
    logic [15:0] svc_addr;
    logic [7:0] taken_cnt;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    evi_ctrl dut (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .src_evt, .ext_pin, .global_enable_instr,
        .global_disable_instr, .request_acknowledge, .int_req, .int_vector, .reset_pc);
    evi_core_model core (.sys_clk, .resetn, .int_req, .int_vector, .ack_on,
        .instr_len, .request_acknowledge, .taken_vec, .svc_addr, .taken_cnt);
    // 200 MHz clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // hang guard: whole run is a few hundred cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            test_done();
        end
    end
    // ----
    // shared tasks
    // ----
    task automatic test_done();
        $display("checked %0d, bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk_val
    // one apb transfer; answer taken at the edge where pready is high
    task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        pwdata <= wd;
        paddr <= {idx, 2'b00};
        @(posedge sys_clk);
        penable <= 1'b1;
        // request stands until the rising edge that samples pready high
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(idx, 1'b1, d, r, e);
    endtask : wr
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(idx, 1'b0, 32'h0, r, e);
        chk_val(r, exp);
    endtask : rd_chk
    // instruction pulse: enable or disable
    task automatic gie(input logic on);
        @(posedge sys_clk);
        global_enable_instr <= on;
        global_disable_instr <= !on;
        @(posedge sys_clk);
        global_enable_instr <= 1'b0;
        global_disable_instr <= 1'b0;
    endtask : gie
    task automatic evt(input logic [17:0] m);
        @(posedge sys_clk);
        src_evt <= m;
        @(posedge sys_clk);
        src_evt <= '0;
    endtask : evt
    task automatic wait_req(input logic [7:0] v);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (int_req !== 1'b1 && n < 20);
        chk_val({31'h0, int_req}, 32'h1);
        chk_val({24'h0, int_vector}, {24'h0, v});
    endtask : wait_req
    task automatic no_req(input int n);
        repeat (n) @(negedge sys_clk);
        chk_val({31'h0, int_req}, 32'h0);
    endtask : no_req
    // let the core grant one request and check the fetched address
    task automatic take(input logic [7:0] v);
        logic [7:0] c;
        int n;
        c = taken_cnt;
        n = 0;
        ack_on <= 1'b1;
        do begin
            @(negedge sys_clk);
            n++;
        end while (taken_cnt === c && n < 40);
        ack_on <= 1'b0;
        chk_val({24'h0, taken_vec}, {24'h0, v});
        chk_val({16'h0, svc_addr}, {16'h0, v ^ 8'h5a, (v + 8'h01) ^ 8'h5a});
    endtask : take
    // mask written only while globally disabled
    task automatic setup(input logic [7:0] m, input logic [7:0] p);
        gie(1'b0);
        wr(evi_pkg::IDX_MASK, {24'h0, m});
        wr(evi_pkg::IDX_PRIO, {24'h0, p});
        wr(evi_pkg::IDX_SRC_EN, 32'h3ffff);
        wr(evi_pkg::IDX_PEND, 32'h0);
        gie(1'b1);
    endtask : setup
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        logic [31:0] d;
        logic e;
        apb(evi_pkg::IDX_MODE, 1'b0, 32'h0, d, e);
        chk_val({30'h0, d[1:0]}, 32'h0);
        chk_val({16'h0, reset_pc}, {16'h0, evi_pkg::RESET_PC});
        apb(10'h3ff, 1'b0, 32'h0, d, e);
        chk_val({31'h0, e}, 32'h1);
        wr(evi_pkg::IDX_REQ, 32'hff);
        rd_chk(evi_pkg::IDX_REQ, 32'h0);
    endtask : t_reset
    task automatic t_regs();
        wr(evi_pkg::IDX_MASK, 32'ha5);
        rd_chk(evi_pkg::IDX_MASK, 32'ha5);
        wr(evi_pkg::IDX_MODE, 32'h1);
        rd_chk(evi_pkg::IDX_MODE, 32'h1);
        gie(1'b0);
        rd_chk(evi_pkg::IDX_MODE, 32'h0);
        gie(1'b1);
        rd_chk(evi_pkg::IDX_MODE, 32'h1);
    endtask : t_regs
    task automatic t_single();
        setup(8'hff, 8'h00);
        evt(18'h00010);
        wait_req(8'hf6);
        rd_chk(evi_pkg::IDX_REQ, 32'h2);
        take(8'hf6);
        no_req(3);
        rd_chk(evi_pkg::IDX_MODE, 32'h0);
        rd_chk(evi_pkg::IDX_PEND, 32'h10);
        wr(evi_pkg::IDX_PEND, 32'h0);
        rd_chk(evi_pkg::IDX_PEND, 32'h0);
    endtask : t_single
    // slow core, in-level order and hardware-cleared sources
    task automatic t_order();
        instr_len <= 4'h5;
        setup(8'hff, 8'h00);
        evt(18'h00030);
        wait_req(8'hf4);
        wr(evi_pkg::IDX_PEND, 32'h0);
        evt(18'h00300);
        wait_req(8'hea);
        take(8'hea);
        gie(1'b1);
        wait_req(8'hec);
        rd_chk(evi_pkg::IDX_PEND, 32'h100);
        wr(evi_pkg::IDX_PEND, 32'h0);
        evt(18'h00400);
        take(8'he6);
        gie(1'b1);
        no_req(4);
        instr_len <= 4'h0;
    endtask : t_order
    task automatic t_mask();
        setup(8'hfd, 8'h00);
        evt(18'h00010);
        no_req(4);
        rd_chk(evi_pkg::IDX_REQ, 32'h2);
        gie(1'b0);
        wr(evi_pkg::IDX_MASK, 32'hff);
        no_req(3);
        gie(1'b1);
        wait_req(8'hf6);
        wr(evi_pkg::IDX_PEND, 32'h0);
        wr(evi_pkg::IDX_SRC_EN, 32'h3ffef);
        evt(18'h00010);
        no_req(4);
        rd_chk(evi_pkg::IDX_REQ, 32'h0);
    endtask : t_mask
    // one source each in groups a, b and c
    task automatic t_prio();
        logic [7:0] pv [3] = '{8'h02, 8'h82, 8'h10};
        logic [7:0] ev [3] = '{8'hf2, 8'he4, 8'hf6};
        setup(8'hff, 8'h00);
        evt(18'h00850);
        rd_chk(evi_pkg::IDX_REQ, 32'h26);
        for (int i = 0; i < 3; i++) begin
            wr(evi_pkg::IDX_PRIO, {24'h0, pv[i]});
            repeat (2) @(posedge sys_clk);
            wait_req(ev[i]);
        end
        wr(evi_pkg::IDX_PEND, 32'h0);
    endtask : t_prio
    task automatic t_pins();
        logic [2:0] pn [3] = '{3'h4, 3'h7, 3'h0};
        logic [7:0] pw [3] = '{8'hde, 8'hd8, 8'hfe};
        setup(8'hff, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            ext_pin[pn[i]] <= 1'b0;
            wait_req(pw[i]);
            wr(evi_pkg::IDX_PEND, 32'h0);
            @(posedge sys_clk);
            ext_pin[pn[i]] <= 1'b1;
            no_req(4);
        end
        evt(18'h02000);
        wait_req(8'he0);
        wr(evi_pkg::IDX_PEND, 32'h0);
    endtask : t_pins
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_single();
        t_order();
        t_mask();
        t_prio();
        t_pins();
        test_done();
    end
endmodule : eight_level_vectored_interrupt_unit_bench
